/* File: logic/omcc_top.v */
// Operating mode and system clock controller with its APB register file.
// Assumes oscillator outputs arrive as free-running pins and that the
// watchdog, voltage detector and idle keep-on bit come from logic on clk.
// Notes on behaviour
// - Fast mode: high clock divided one to sixty-four.
// - Slow mode: low oscillator runs CPU, high off.
// - Halt, no keepers: deepest sleep stops everything.
// - Voltage detect enabled blocks the deepest sleep.
// - Second sleep keeps substitute and watchdog clocks.
// - Idle halt, keep clear: system clock stops.
// - Idle halt, keep set: system clock continues.
// - Divider field picks substitute or divided clock.
// - Select bit one picks undivided high clock.
// - Switch to substitute turns high oscillator off.
// - Low ready: zero in deepest sleep, then counts.
// - High ready: counts after start, zero when stopped.
// - Idle bit chooses idle or sleep on halt.
// - Fast wake runs substitute clock after crystal wake.
// - Fast wake only from second sleep, first idle.
// - Crystal fast wake switches back after ready.
// - High RC oscillator ignores fast wake, waits its count.
// - No fast wake leaving the deepest sleep.
`timescale 1ns/100ps
`default_nettype none
`include "omcc_consts.vh"

module omcc_top (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        high_osc_in,
  input  wire        sub_osc_in,
  input  wire        high_is_rc,
  input  wire        low_is_rc,
  input  wire        watchdog_enable,
  input  wire        low_voltage_detect_enable,
  input  wire        idle_sysclk_keep_on,
  input  wire        halt_req,
  input  wire        wake_req,
  output reg         sys_clk,
  output reg         cpu_run,
  output reg         high_osc_enable,
  output reg         sub_osc_enable,
  output reg         watchdog_clk_enable,
  output reg         time_base_clk_enable,
  output reg  [2:0]  op_mode,
  output reg         irq
);

  localparam ST_RUN    = 3'd0;
  localparam ST_SYSCLK_OFF_IDLE_MODE  = 3'd1;
  localparam ST_SYSCLK_ON_IDLE_MODE  = 3'd2;
  localparam ST_DEEPEST_SLEEP_MODE = 3'd3;
  localparam ST_SUB_CLOCK_SLEEP_MODE = 3'd4;
  localparam ST_WAKE   = 3'd5;

  wire       high_rise;
  wire       high_fall;
  wire       sub_rise;
  wire       sub_fall;

  reg  [2:0] state;
  reg  [2:0] cks;
  reg        fast_wake_enable;
  reg        idle_on_halt_enable;
  reg        high_low_clock_select;
  reg        low_osc_ready_flag;
  reg        high_osc_ready_flag;
  reg  [7:0] high_cnt;
  reg  [7:0] low_cnt;
  reg  [2:0] act_src;
  reg  [5:0] div_cnt;
  reg        fw_active;
  reg        halt_pend;
  reg  [3:0] irq_status;
  reg  [3:0] irq_enable;
  reg        high_ready_d;
  reg        low_ready_d;

  reg  [2:0] reg_src;
  reg  [2:0] req_src;
  reg  [5:0] div_limit;
  reg        src_ready;
  reg        tick;
  reg        clk_on;
  reg  [7:0] high_target;
  reg  [7:0] low_target;
  reg  [3:0] ev;
  reg  [2:0] next_state;
  reg        next_fw;
  reg  [7:0] mode_rd;

  wire       apb_access = psel & penable & ~pready;
  wire       apb_write  = apb_access & pwrite;
  wire       hit_mode   = (paddr == `OMCC_OFS_MODE_CTRL);
  wire       hit_stat   = (paddr == `OMCC_OFS_IRQ_STATUS);
  wire       hit_en     = (paddr == `OMCC_OFS_IRQ_ENABLE);
  wire       hit_clr    = (paddr == `OMCC_OFS_IRQ_CLEAR);
  wire [7:0] mode_reset = `OMCC_MODE_RESET;

  omcc_osc_sample u_high_sample (
    .clk    (clk),
    .rst    (rst),
    .osc_in (high_osc_in),
    .rise   (high_rise),
    .fall   (high_fall)
  );

  omcc_osc_sample u_sub_sample (
    .clk    (clk),
    .rst    (rst),
    .osc_in (sub_osc_in),
    .rise   (sub_rise),
    .fall   (sub_fall)
  );

  // Source requested by software, then overridden during a fast wake.
  always @* begin
    if (high_low_clock_select)
      reg_src = `OMCC_SRC_HIGH;
    else if (cks[2:1] == 2'b00)
      reg_src = `OMCC_SRC_SUB;
    else
      reg_src = cks;
    req_src = fw_active ? `OMCC_SRC_SUB : reg_src;
    // Half period in high clock rising edges, minus one.
    div_limit = (6'h01 << (3'd7 - act_src)) - 6'h01;
    src_ready = (act_src == `OMCC_SRC_SUB) ? low_osc_ready_flag : high_osc_ready_flag;
    // A source edge that should toggle the system clock.
    if (!src_ready)
      tick = 1'b0;
    else if (act_src == `OMCC_SRC_SUB)
      tick = sub_rise | sub_fall;
    else if (act_src == `OMCC_SRC_HIGH)
      tick = high_rise | high_fall;
    else
      tick = high_rise && (div_cnt == div_limit);
    high_target = high_is_rc ? `OMCC_INTERNAL_HIGH_RC_OSC_READY_CYC : `OMCC_HXT_READY_CYC;
    low_target  = low_is_rc ? `OMCC_INTERNAL_LOW_RC_OSC_READY_CYC : `OMCC_LXT_READY_CYC;
  end

  // System clock generator. A source change is applied only while the
  // output is low, so every high phase is a full one; the low phase
  // around a change may be longer than either source would give.
  always @(posedge clk) begin
    if (rst) begin
      sys_clk <= 1'b0;
      act_src <= `OMCC_SRC_HIGH;
      div_cnt <= 6'h00;
    end else if (!sys_clk && act_src != req_src &&
                 ((req_src == `OMCC_SRC_SUB) ? low_osc_ready_flag : high_osc_ready_flag)) begin
      act_src <= req_src;
      div_cnt <= 6'h00;
    end else begin
      if (high_rise)
        div_cnt <= (div_cnt == div_limit) ? 6'h00 : div_cnt + 6'h01;
      if (tick && (clk_on || sys_clk))
        sys_clk <= ~sys_clk;
    end
  end

  // Oscillator ready counters; a stopped oscillator loses its flag.
  always @(posedge clk) begin
    if (rst) begin
      high_cnt            <= 8'h00;
      low_cnt             <= 8'h00;
      high_osc_ready_flag <= 1'b0;
      low_osc_ready_flag  <= 1'b0;
    end else begin
      if (!high_osc_enable) begin
        high_cnt            <= 8'h00;
        high_osc_ready_flag <= 1'b0;
      end else if (high_rise && !high_osc_ready_flag) begin
        high_cnt <= high_cnt + 8'h01;
        if (high_cnt + 8'h01 == high_target)
          high_osc_ready_flag <= 1'b1;
      end
      if (!sub_osc_enable) begin
        low_cnt            <= 8'h00;
        low_osc_ready_flag <= 1'b0;
      end else if (sub_rise && !low_osc_ready_flag) begin
        low_cnt <= low_cnt + 8'h01;
        if (low_cnt + 8'h01 == low_target)
          low_osc_ready_flag <= 1'b1;
      end
    end
  end

  // Mode sequencer for halt and wake-up.
  always @* begin
    next_state = state;
    next_fw    = fw_active;
    if (fw_active && high_osc_ready_flag)
      next_fw = 1'b0;
    case (state)
      ST_RUN: begin
        // Halt waits for a low system clock so no pulse is cut short.
        if (halt_pend && !sys_clk) begin
          if (idle_on_halt_enable)
            next_state = idle_sysclk_keep_on ? ST_SYSCLK_ON_IDLE_MODE : ST_SYSCLK_OFF_IDLE_MODE;
          else if (low_voltage_detect_enable || watchdog_enable)
            next_state = ST_SUB_CLOCK_SLEEP_MODE;
          else
            next_state = ST_DEEPEST_SLEEP_MODE;
        end
      end
      ST_SYSCLK_OFF_IDLE_MODE, ST_SUB_CLOCK_SLEEP_MODE: begin
        if (wake_req) begin
          if (fast_wake_enable && !high_is_rc && reg_src != `OMCC_SRC_SUB) begin
            next_state = ST_RUN;
            next_fw    = 1'b1;
          end else begin
            next_state = ST_WAKE;
          end
        end
      end
      ST_SYSCLK_ON_IDLE_MODE, ST_DEEPEST_SLEEP_MODE: begin
        if (wake_req)
          next_state = ST_WAKE;
      end
      ST_WAKE: begin
        if ((reg_src == `OMCC_SRC_SUB) ? low_osc_ready_flag : high_osc_ready_flag)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
    // Gate on the next state, so the edge that enters a halt never starts a fresh high phase.
    clk_on = (next_state == ST_RUN) || (next_state == ST_SYSCLK_ON_IDLE_MODE);
  end

  // Events that set sticky interrupt status bits.
  always @* begin
    ev = 4'h0;
    ev[`OMCC_EV_HALT]       = (state == ST_RUN) && (next_state != ST_RUN);
    ev[`OMCC_EV_WAKE]       = (state != ST_RUN) && (next_state == ST_RUN);
    ev[`OMCC_EV_HIGH_READY] = high_osc_ready_flag & ~high_ready_d;
    ev[`OMCC_EV_LOW_READY]  = low_osc_ready_flag & ~low_ready_d;
    mode_rd = {cks, fast_wake_enable, low_osc_ready_flag, high_osc_ready_flag,
               idle_on_halt_enable, high_low_clock_select};
  end

  // State, enables and mode output.
  always @(posedge clk) begin
    if (rst) begin
      state                <= ST_RUN;
      fw_active            <= 1'b0;
      halt_pend            <= 1'b0;
      cpu_run              <= 1'b1;
      high_osc_enable      <= 1'b0;
      sub_osc_enable       <= 1'b0;
      watchdog_clk_enable  <= 1'b0;
      time_base_clk_enable <= 1'b0;
      op_mode              <= `OMCC_MODE_FAST;
      high_ready_d         <= 1'b0;
      low_ready_d          <= 1'b0;
    end else begin
      state        <= next_state;
      fw_active    <= next_fw;
      high_ready_d <= high_osc_ready_flag;
      low_ready_d  <= low_osc_ready_flag;
      if (state != ST_RUN)
        halt_pend <= 1'b0;
      else if (halt_req)
        halt_pend <= 1'b1;
      cpu_run <= (next_state == ST_RUN);
      // High oscillator runs while used or requested; off once on substitute.
      case (next_state)
        ST_RUN:   high_osc_enable <= (act_src != `OMCC_SRC_SUB) || (reg_src != `OMCC_SRC_SUB);
        ST_SYSCLK_ON_IDLE_MODE: high_osc_enable <= (act_src != `OMCC_SRC_SUB);
        ST_WAKE:  high_osc_enable <= (reg_src != `OMCC_SRC_SUB);
        default:  high_osc_enable <= 1'b0;
      endcase
      sub_osc_enable       <= (next_state != ST_DEEPEST_SLEEP_MODE);
      watchdog_clk_enable  <= (next_state != ST_DEEPEST_SLEEP_MODE) && watchdog_enable;
      time_base_clk_enable <= (next_state != ST_DEEPEST_SLEEP_MODE) && (next_state != ST_SUB_CLOCK_SLEEP_MODE);
      case (next_state)
        // Slow only once the high oscillator is released; a fast wake still reports fast.
        ST_RUN:    op_mode <= (act_src == `OMCC_SRC_SUB && reg_src == `OMCC_SRC_SUB) ?
                              `OMCC_MODE_SLOW : `OMCC_MODE_FAST;
        ST_SYSCLK_OFF_IDLE_MODE:  op_mode <= `OMCC_MODE_SYSCLK_OFF_IDLE_MODE;
        ST_SYSCLK_ON_IDLE_MODE:  op_mode <= `OMCC_MODE_SYSCLK_ON_IDLE_MODE;
        ST_DEEPEST_SLEEP_MODE: op_mode <= `OMCC_MODE_DEEPEST_SLEEP_MODE;
        ST_SUB_CLOCK_SLEEP_MODE: op_mode <= `OMCC_MODE_SUB_CLOCK_SLEEP_MODE;
        default:   op_mode <= `OMCC_MODE_WAKING;
      endcase
    end
  end

  // Register writes; the two ready flags ignore writes.
  always @(posedge clk) begin
    if (rst) begin
      cks                   <= mode_reset[`OMCC_BIT_CKS_HI:`OMCC_BIT_CKS_LO];
      fast_wake_enable      <= mode_reset[`OMCC_BIT_FAST_WAKE];
      idle_on_halt_enable   <= mode_reset[`OMCC_BIT_IDLE_HALT];
      high_low_clock_select <= mode_reset[`OMCC_BIT_HL_SELECT];
      irq_enable            <= 4'h0;
    end else if (apb_write) begin
      if (hit_mode) begin
        cks                   <= pwdata[`OMCC_BIT_CKS_HI:`OMCC_BIT_CKS_LO];
        fast_wake_enable      <= pwdata[`OMCC_BIT_FAST_WAKE];
        idle_on_halt_enable   <= pwdata[`OMCC_BIT_IDLE_HALT];
        high_low_clock_select <= pwdata[`OMCC_BIT_HL_SELECT];
      end
      if (hit_en)
        irq_enable <= pwdata[3:0];
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle.
  always @(posedge clk) begin
    if (rst) begin
      irq_status <= 4'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~((apb_write && hit_clr) ? pwdata[3:0] : 4'h0)) | ev;
      irq        <= |(irq_status & irq_enable);
    end
  end

  // APB answer one cycle into the access phase; unmapped reads give zero.
  always @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access && !(hit_mode || hit_stat || hit_en || hit_clr);
      prdata  <= 32'h00000000;
      if (apb_access && !pwrite) begin
        if (hit_mode)
          prdata <= {24'h000000, mode_rd};
        else if (hit_stat)
          prdata <= {28'h0000000, irq_status};
        else if (hit_en)
          prdata <= {28'h0000000, irq_enable};
      end
    end
  end

endmodule // omcc_top

`default_nettype wire

/* File: logic/omcc_consts.vh */
// Constants for the operating mode and system clock controller.
// Assumes inclusion by bare name from every file of the block except the oscillator sampler.
`ifndef OMCC_CONSTS_VH
`define OMCC_CONSTS_VH

// Register byte offsets on the APB slave.
`define OMCC_OFS_MODE_CTRL   8'h00
`define OMCC_OFS_IRQ_STATUS  8'h04
`define OMCC_OFS_IRQ_ENABLE  8'h08
`define OMCC_OFS_IRQ_CLEAR   8'h0c

// Field positions of the system mode control register.
`define OMCC_BIT_CKS_HI      7
`define OMCC_BIT_CKS_LO      5
`define OMCC_BIT_FAST_WAKE   4
`define OMCC_BIT_LOW_READY   3
`define OMCC_BIT_HIGH_READY  2
`define OMCC_BIT_IDLE_HALT   1
`define OMCC_BIT_HL_SELECT   0
`define OMCC_MODE_RESET      8'h03

// Interrupt event bit positions.
`define OMCC_EV_HALT         0
`define OMCC_EV_WAKE         1
`define OMCC_EV_HIGH_READY   2
`define OMCC_EV_LOW_READY    3

// Oscillator start-up counts, in cycles of the oscillator concerned.
`define OMCC_HXT_READY_CYC   8'd128
`define OMCC_INTERNAL_HIGH_RC_OSC_READY_CYC  8'd16
`define OMCC_LXT_READY_CYC   8'd128
`define OMCC_INTERNAL_LOW_RC_OSC_READY_CYC  8'd2

// System clock source codes; codes 2 to 7 are the divided high clock.
`define OMCC_SRC_SUB         3'd0
`define OMCC_SRC_HIGH        3'd1

// Operating mode codes shown on the mode output.
`define OMCC_MODE_FAST       3'd0
`define OMCC_MODE_SLOW       3'd1
`define OMCC_MODE_SYSCLK_OFF_IDLE_MODE      3'd2
`define OMCC_MODE_SYSCLK_ON_IDLE_MODE      3'd3
`define OMCC_MODE_DEEPEST_SLEEP_MODE     3'd4
`define OMCC_MODE_SUB_CLOCK_SLEEP_MODE     3'd5
`define OMCC_MODE_WAKING     3'd6

`endif

/* File: logic/omcc_osc_sample.v */
// Samples one free-running oscillator output into the clk domain.
// Assumes the oscillator runs well below half the clk rate.
`timescale 1ns/100ps
`default_nettype none

module omcc_osc_sample (
  input  wire clk,
  input  wire rst,
  input  wire osc_in,
  output reg  rise,
  output reg  fall
);

  reg [2:0] sync;
  reg       level;

  // Three stages; a change counts only once the last two agree.
  always @(posedge clk) begin
    if (rst) begin
      sync  <= 3'h0;
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      sync <= {sync[1:0], osc_in};
      rise <= 1'b0;
      fall <= 1'b0;
      if (sync[2] == sync[1] && sync[2] != level) begin
        level <= sync[2];
        rise  <= sync[2];
        fall  <= ~sync[2];
      end
    end
  end

endmodule // omcc_osc_sample

`default_nettype wire

/* File: verification/omcc_sva.sv */
// Concurrent checks on the ports of the mode and clock controller.
// Assumes a bind onto omcc_top, one clk domain with synchronous rst.
`timescale 1ns/100ps
`default_nettype none
`include "omcc_consts.vh"
module omcc_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       low_voltage_detect_enable,
  input wire logic       watchdog_enable,
  input wire logic       sys_clk,
  input wire logic       cpu_run,
  input wire logic       high_osc_enable,
  input wire logic       sub_osc_enable,
  input wire logic       watchdog_clk_enable,
  input wire logic       time_base_clk_enable,
  input wire logic [2:0] op_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Mode terms; registered enables may lag a new mode by a cycle, so most checks wait for a settled mode.
  wire s0   = op_mode == `OMCC_MODE_DEEPEST_SLEEP_MODE;
  wire s1   = op_mode == `OMCC_MODE_SUB_CLOCK_SLEEP_MODE;
  wire idl  = op_mode == `OMCC_MODE_SYSCLK_OFF_IDLE_MODE || op_mode == `OMCC_MODE_SYSCLK_ON_IDLE_MODE;
  wire stop = s0 || s1 || op_mode == `OMCC_MODE_SYSCLK_OFF_IDLE_MODE;
  wire run  = op_mode == `OMCC_MODE_FAST || op_mode == `OMCC_MODE_SLOW;
  apb_ready_a: assert property (psel && penable && !pready |=> pready) else $error("no pready");
  unmapped_err_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
    else $error("pslverr wrong");
  cpu_run_mode_a: assert property (cpu_run == run) else $error("cpu_run wrong");
  deepest_sleep_mode_stops_a: assert property (s0 && $past(s0) |-> !sub_osc_enable && !watchdog_clk_enable
    && !time_base_clk_enable && !high_osc_enable) else $error("clock on in deepest sleep");
  deepest_sleep_mode_guard_a: assert property (s0 |-> !low_voltage_detect_enable) else $error("deepest sleep with lvd");
  sub_clock_sleep_mode_keeps_a: assert property (s1 && $past(s1) |-> sub_osc_enable && !time_base_clk_enable
    && watchdog_clk_enable == watchdog_enable) else $error("sub_clock_sleep_mode clocks wrong");
  idle_keeps_a: assert property (idl && $past(idl) |-> sub_osc_enable && time_base_clk_enable)
    else $error("idle clocks off");
  slow_high_off_a: assert property ((op_mode == `OMCC_MODE_SLOW)[*8] |-> !high_osc_enable)
    else $error("high osc on in slow");
  halt_clk_low_a: assert property (stop && $past(stop) |-> !sys_clk && $stable(sys_clk))
    else $error("sys_clk moves while stopped");
  clk_pulse_a: assert property ($rose(sys_clk) |-> sys_clk[*3]) else $error("short sys_clk pulse");
  cover property ($rose(s0));
  cover property ($rose(op_mode == `OMCC_MODE_SYSCLK_ON_IDLE_MODE));
  cover property (pready && pslverr);
endmodule // omcc_sva
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the mode and clock controller.
// Assumes omcc_top and omcc_sva are compiled first; the bench drives all ports.
`timescale 1ns/100ps
`default_nettype none
`include "omcc_consts.vh"
module tb_top;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        high_osc_in, sub_osc_in, high_is_rc, low_is_rc, watchdog_enable;
  logic        low_voltage_detect_enable, idle_sysclk_keep_on, halt_req, wake_req;
  logic        sys_clk, cpu_run, high_osc_enable, sub_osc_enable, watchdog_clk_enable, time_base_clk_enable;
  logic [2:0]  op_mode, hc, sc;
  logic [31:0] r;
  logic        e;
  int          n_errors, samples_checked, cyc;
  omcc_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .high_osc_in(high_osc_in),
    .sub_osc_in(sub_osc_in), .high_is_rc(high_is_rc), .low_is_rc(low_is_rc), .watchdog_enable(watchdog_enable),
    .low_voltage_detect_enable(low_voltage_detect_enable), .idle_sysclk_keep_on(idle_sysclk_keep_on),
    .halt_req(halt_req), .wake_req(wake_req), .sys_clk(sys_clk), .cpu_run(cpu_run),
    .high_osc_enable(high_osc_enable), .sub_osc_enable(sub_osc_enable), .watchdog_clk_enable(watchdog_clk_enable),
    .time_base_clk_enable(time_base_clk_enable), .op_mode(op_mode), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Oscillator pins: high toggles every 4 clocks, substitute every 6, slow enough for the pin samplers.
  always @(posedge clk) begin
    hc <= (hc == 3'h3) ? 3'h0 : hc + 3'h1;
    sc <= (sc == 3'h5) ? 3'h0 : sc + 3'h1;
    if (hc == 3'h3) high_osc_in <= ~high_osc_in;
    if (sc == 3'h5) sub_osc_in <= ~sub_osc_in;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1, "pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(r, exp, what);
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (op_mode !== m && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk({29'h0, op_mode}, {29'h0, m}, "op_mode");
  endtask
  task automatic pulse(input logic hlt);
    @(posedge clk);
    if (hlt) halt_req <= 1'b1;
    else wake_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
  endtask
  // Clock count between two sys_clk rises, after letting a source change settle.
  task automatic chk_period(input int exp, input string what);
    int n, k;
    logic p;
    for (k = 0; k < 3; k++) begin
      n = 0;
      do begin
        p = sys_clk;
        @(posedge clk);
        n++;
      end while (!(sys_clk === 1'b1 && p === 1'b0) && n < 3000);
    end
    chk(n, exp, what);
  endtask
  task automatic t_regs();
    rdc(8'h00, 32'h03, "mode reset");
    rdc(8'h08, 32'h00, "irq enable reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped err");
    repeat (300) @(posedge clk);
    rdc(8'h00, 32'h0f, "ready flags");
    chk_period(8, "undivided");
  endtask
  task automatic t_clocks();
    int c;
    for (c = 2; c < 8; c++) begin
      apb(1'b1, 8'h00, {24'h0, c[2:0], 5'h02});
      chk_period(8 << (8 - c), "divided");
    end
    rdc(8'h00, 32'hee, "ready bits read only");
    apb(1'b1, 8'h00, 32'h22);
    chk_period(12, "sub code 001");
    repeat (20) @(posedge clk);
    chk({31'h0, high_osc_enable}, 32'h0, "high osc off");
    chk({29'h0, op_mode}, {29'h0, `OMCC_MODE_SLOW}, "slow");
    rdc(8'h00, 32'h2a, "high ready cleared");
    apb(1'b1, 8'h00, 32'h02);
    chk_period(12, "sub code 000");
    apb(1'b1, 8'h00, 32'h03);
    wait_mode(`OMCC_MODE_FAST);
  endtask
  // Halt outcomes; each entry is idle bit, keep bit, lvd, watchdog, expected mode.
  task automatic t_halt();
    logic [6:0] tb [5] = '{7'h04, 7'h15, 7'h0d, 7'h5a, 7'h63};
    int i;
    apb(1'b1, 8'h08, 32'h1);
    for (i = 0; i < 5; i++) begin
      idle_sysclk_keep_on <= tb[i][5];
      low_voltage_detect_enable <= tb[i][4];
      watchdog_enable <= tb[i][3];
      apb(1'b1, 8'h00, tb[i][6] ? 32'h03 : 32'h01);
      pulse(1'b1);
      wait_mode(tb[i][2:0]);
      rdc(8'h00, {29'h0, tb[i][2:0] == 3'h3, tb[i][6], 1'b1} | (tb[i][2:0] == 3'h4 ? 32'h0 : 32'h8),
        "halted flags");
      chk({31'h0, irq}, 32'h1, "irq on halt");
      apb(1'b1, 8'h0c, 32'h1);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      pulse(1'b0);
      wait_mode(`OMCC_MODE_FAST);
    end
    rdc(8'h04, 32'h0e, "status");
    apb(1'b1, 8'h08, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq enabled");
    apb(1'b1, 8'h08, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    idle_sysclk_keep_on <= 1'b0;
    watchdog_enable <= 1'b0;
  endtask
  // Wake with fast wake set; the mode seen shortly after wake tells whether it applied.
  task automatic fw(input logic [7:0] m, input logic lvd, input logic rc, input logic [2:0] first);
    low_voltage_detect_enable <= lvd;
    high_is_rc <= rc;
    apb(1'b1, 8'h00, {24'h0, m});
    pulse(1'b1);
    repeat (40) @(posedge clk);
    pulse(1'b0);
    repeat (10) @(posedge clk);
    chk({29'h0, op_mode}, {29'h0, first}, "mode after wake");
  endtask
  task automatic t_fast();
    fw(8'h13, 1'b0, 1'b0, `OMCC_MODE_FAST);
    chk_period(12, "fast wake on sub");
    repeat (1200) @(posedge clk);
    chk_period(8, "back on crystal");
    fw(8'h11, 1'b0, 1'b0, `OMCC_MODE_WAKING);
    wait_mode(`OMCC_MODE_FAST);
    fw(8'h11, 1'b1, 1'b1, `OMCC_MODE_WAKING);
    wait_mode(`OMCC_MODE_FAST);
    // Low crystal: its ready flag needs 128 substitute rising edges after leaving the deepest sleep.
    low_is_rc <= 1'b0;
    fw(8'h11, 1'b0, 1'b1, `OMCC_MODE_WAKING);
    wait_mode(`OMCC_MODE_FAST);
    rdc(8'h00, 32'h15, "low crystal not ready");
    repeat (1600) @(posedge clk);
    rdc(8'h00, 32'h1d, "low crystal ready");
  endtask
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, halt_req, wake_req} = {1'b1, 45'h0};
    {high_osc_in, sub_osc_in, hc, sc, high_is_rc, low_is_rc} = {8'h0, 2'h3};
    {watchdog_enable, low_voltage_detect_enable, idle_sysclk_keep_on} = 3'h0;
    {n_errors, samples_checked, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_clocks();
    t_halt();
    t_fast();
    give_verdict();
  end
endmodule // tb_top
bind omcc_top omcc_sva u_sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .low_voltage_detect_enable(low_voltage_detect_enable),
  .watchdog_enable(watchdog_enable), .sys_clk(sys_clk), .cpu_run(cpu_run), .high_osc_enable(high_osc_enable),
  .sub_osc_enable(sub_osc_enable), .watchdog_clk_enable(watchdog_clk_enable),
  .time_base_clk_enable(time_base_clk_enable), .op_mode(op_mode));
`default_nettype wire
